/* File: design/sttl_decoder.sv */
/*
  Decoder and executor for the three skip-on-zero tests and the timer-1 load.
  Assumes instruction words, operands and flags come from core logic on clk_sys,
  one word per cycle at most, marked by instr_valid.
*/
`timescale 1ns/10ps
`include "sttl_map.svh"

module sttl_decoder
  import sttl_pkg::*;
#(
  parameter int DATA_W = 4,
  parameter int PORT_N = 6
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Instruction stream
  input wire logic instr_valid,
  input wire logic [9:0] instr_word,
  // Operands
  input wire logic [DATA_W-1:0] mem_nibble,
  input wire logic carry_flag,
  input wire logic [DATA_W-1:0] y_reg,
  input wire logic [DATA_W-1:0] acc,
  input wire logic [DATA_W-1:0] b_reg,
  input wire logic [PORT_N-1:0] port_d,
  // Results
  output logic exec_en,
  output logic skipped,
  output logic skip_set,
  output logic bad_sel,
  output logic t1_load,
  output logic [2*DATA_W-1:0] timer1_value,
  output logic [2*DATA_W-1:0] timer1_reload_register
);

  // Widths the logic is built for; others are refused at elaboration
  if (DATA_W != 4 || PORT_N != 6) begin : g_bad_width
    $error("sttl_decoder supports DATA_W=4 and PORT_N=6 only");
  end

  // State register, its next value and the port select
  sttl_regs_t s_r;
  sttl_regs_t s_nxt;
  logic y_ok;
  logic port_bit;

  // Port bit select, valid only for Y up to the last port line
  always_comb begin
    y_ok = (y_reg <= `STTL_Y_LAST);
    port_bit = y_ok ? port_d[y_reg[`STTL_Y_IDX_HI:`STTL_Y_IDX_LO]] : 1'b1;
  end

  // Next-state decode: each valid word is executed, discarded or resolves the port test
  always_comb begin
    s_nxt = s_r;
    // Result flags are one-cycle pulses
    s_nxt.exec_en = 1'b0;
    s_nxt.skipped = 1'b0;
    s_nxt.skip_set = 1'b0;
    s_nxt.t1_load = 1'b0;
    s_nxt.bad_sel = 1'b0;
    if (instr_valid) begin
      unique case (s_r.state)
        ST_PORT2: begin
          // Second word of the port test resolves the skip; Y past the last line never skips
          s_nxt.state = ST_RUN;
          s_nxt.exec_en = 1'b1;
          s_nxt.bad_sel = ~y_ok;
          s_nxt.skip_pend = ~port_bit;
          s_nxt.skip_set = ~port_bit;
        end
        ST_RUN: begin
          if (s_r.skip_pend) begin
            // Discard this word; nothing is written and only skipped is raised
            s_nxt.skip_pend = 1'b0;
            s_nxt.skipped = 1'b1;
          end else begin
            // Execute this word; unknown opcodes only raise exec_en
            s_nxt.exec_en = 1'b1;
            if ((instr_word & `STTL_OP_MEM_BIT_MASK) == `STTL_OP_MEM_BIT) begin
              s_nxt.skip_pend = ~mem_nibble[instr_word[`STTL_BIT_IDX_HI:`STTL_BIT_IDX_LO]];
              s_nxt.skip_set = s_nxt.skip_pend;
            end else if (instr_word == `STTL_OP_CARRY_TEST) begin
              // Carry is only read here, never written
              s_nxt.skip_pend = ~carry_flag;
              s_nxt.skip_set = ~carry_flag;
            end else if (instr_word == `STTL_OP_PORT_WORD1) begin
              // Operands of the port test are read with its second word
              s_nxt.state = ST_PORT2;
            end else if (instr_word == `STTL_OP_TIMER_LOAD) begin
              // B fills the upper nibble, the accumulator the lower, of both registers
              s_nxt.t1_load = 1'b1;
              s_nxt.t1_val = {b_reg, acc};
              s_nxt.reload_val = {b_reg, acc};
            end
          end
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  always_comb begin
    exec_en = s_r.exec_en;
    skipped = s_r.skipped;
    skip_set = s_r.skip_set;
    bad_sel = s_r.bad_sel;
    t1_load = s_r.t1_load;
    timer1_value = s_r.t1_val;
    timer1_reload_register = s_r.reload_val;
  end

  // Assertions sample on the system clock and rest while reset is high
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // A word that the run state decodes and executes
  sequence run_word_s;
    instr_valid && s_r.state == ST_RUN && !s_r.skip_pend;
  endsequence

  // A word that arrives while a skip is pending and is to be discarded
  sequence discard_word_s;
    instr_valid && s_r.state == ST_RUN && s_r.skip_pend;
  endsequence

  // The second word of the two-word port test
  sequence port_second_s;
    instr_valid && s_r.state == ST_PORT2;
  endsequence

  // Memory bit test executes and skips exactly when the chosen bit is zero
  mem_bit_skip_a: assert property (
      run_word_s ##0 ((instr_word & `STTL_OP_MEM_BIT_MASK) == `STTL_OP_MEM_BIT) |=>
      exec_en && skip_set == !$past(mem_nibble[instr_word[`STTL_BIT_IDX_HI:`STTL_BIT_IDX_LO]]))
    else $error("memory bit test gave wrong skip");

  // Carry test executes in one word and skips exactly when carry is zero
  carry_skip_a: assert property (
      run_word_s ##0 (instr_word == `STTL_OP_CARRY_TEST) |=>
      exec_en && skip_set == !$past(carry_flag))
    else $error("carry test gave wrong skip");

  // Carry test has no side effect on timers, state or selection
  carry_kept_a: assert property (
      run_word_s ##0 (instr_word == `STTL_OP_CARRY_TEST) |=>
      !t1_load && !bad_sel && s_r.state == ST_RUN && $stable(timer1_value))
    else $error("carry test had side effect");

  // First word of the port test only arms the second word
  port_two_word_a: assert property (
      run_word_s ##0 (instr_word == `STTL_OP_PORT_WORD1) |=>
      exec_en && !skip_set && s_r.state == ST_PORT2)
    else $error("port test first word wrong");

  // Second word of the port test skips only on a zero bit at a valid Y
  port_second_a: assert property (
      port_second_s |=>
      exec_en && s_r.state == ST_RUN &&
      skip_set == $past(y_reg <= `STTL_Y_LAST && !port_d[y_reg[`STTL_Y_IDX_HI:`STTL_Y_IDX_LO]]))
    else $error("port test second word wrong");

  // A Y value past the last port line is flagged and never skips
  port_bad_sel_a: assert property (
      port_second_s ##0 (y_reg > `STTL_Y_LAST) |=>
      bad_sel && !skip_set)
    else $error("invalid Y caused a skip");

  // Timer load writes B high and the accumulator low into both registers
  timer_load_a: assert property (
      run_word_s ##0 (instr_word == `STTL_OP_TIMER_LOAD) |=>
      t1_load && timer1_value == {$past(b_reg), $past(acc)} &&
      timer1_reload_register == {$past(b_reg), $past(acc)})
    else $error("timer 1 load value wrong");

  // Timer and reload register always hold the same loaded value
  reload_match_a: assert property (
      timer1_reload_register == timer1_value)
    else $error("reload register differs from timer");

  // Timer value moves only together with a load pulse
  timer_hold_a: assert property (
      !t1_load |-> $stable(timer1_value))
    else $error("timer changed without a load");

  // A skip decision arms the discard of the next word
  skip_arm_a: assert property (
      skip_set |-> s_r.skip_pend)
    else $error("skip decided but not armed");

  // The discarded word acts as a no-operation
  skip_nop_a: assert property (
      discard_word_s |=>
      skipped && !exec_en && !t1_load && !skip_set && $stable(timer1_value) &&
      $stable(timer1_reload_register))
    else $error("skipped word was executed");

  // Only one word is discarded per skip decision
  skip_clear_a: assert property (
      discard_word_s |=>
      !s_r.skip_pend)
    else $error("skip stayed pending after discard");

  // A word is never both executed and discarded
  skip_excl_a: assert property (
      !(skipped && exec_en))
    else $error("word both executed and discarded");

endmodule // sttl_decoder

/* File: design/sttl_map.svh */
/*
  Opcode and field constants for the skip-test and timer-1 load decoder.
  Assumes 10-bit instruction words and 4-bit data registers.
*/
`ifndef STTL_MAP_SVH
`define STTL_MAP_SVH

// Opcodes and compare masks
`define STTL_OP_MEM_BIT_MASK 10'h3fc
`define STTL_OP_MEM_BIT 10'h020
`define STTL_OP_CARRY_TEST 10'h02f
`define STTL_OP_PORT_WORD1 10'h024
`define STTL_OP_PORT_WORD2 10'h02b
`define STTL_OP_TIMER_LOAD 10'h230

// Fields
`define STTL_BIT_IDX_HI 1
`define STTL_BIT_IDX_LO 0
`define STTL_Y_LAST 4'h5
`define STTL_Y_IDX_HI 2
`define STTL_Y_IDX_LO 0

`endif

/* File: design/sttl_pkg.sv */
/*
  Types for the skip-test and timer-1 load decoder.
  Assumes nothing beyond the map header.
*/
package sttl_pkg;

  typedef enum logic [0:0] {ST_RUN, ST_PORT2} sttl_state_t;

  typedef struct packed {
    sttl_state_t state;
    logic skip_pend;
    logic exec_en;
    logic skipped;
    logic skip_set;
    logic t1_load;
    logic bad_sel;
    logic [7:0] t1_val;
    logic [7:0] reload_val;
  } sttl_regs_t;

endpackage

/* File: testbench/skip_test_and_timer_load_ops_test.sv */
/*
  Self-checking bench for sttl_decoder: skip tests and timer-1 load.
  Assumes the design files and sttl_map.svh are compiled first.
*/
`timescale 1ns/10ps
`include "sttl_map.svh"
module skip_test_and_timer_load_ops_test;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  logic carry_flag = 1'b0;
  logic [9:0] instr_word = 10'h000;
  logic [3:0] mem_nibble = 4'h0, y_reg = 4'h0, acc = 4'h0, b_reg = 4'h0;
  logic [5:0] port_d = 6'h00;
  logic exec_en, skipped, skip_set, bad_sel, t1_load;
  logic [7:0] timer1_value, timer1_reload_register;
  logic [7:0] exp_t = 8'h00, k = 8'h00;
  int n_mismatch = 0, checks = 0;

  sttl_decoder sttl_decoder_inst (.clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .mem_nibble(mem_nibble), .carry_flag(carry_flag), .y_reg(y_reg),
    .acc(acc), .b_reg(b_reg), .port_d(port_d), .exec_en(exec_en), .skipped(skipped),
    .skip_set(skip_set), .bad_sel(bad_sel), .t1_load(t1_load), .timer1_value(timer1_value),
    .timer1_reload_register(timer1_reload_register));

  // Clock
  initial forever #5 clk_sys = ~clk_sys;

  // Compare and count
  task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One word with its operands, then look one cycle later
  task send(input logic [9:0] w, input logic [3:0] m, input logic c, input logic [3:0] y,
            input logic [5:0] p, input logic [7:0] ba);
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr_word <= w;
    mem_nibble <= m;
    carry_flag <= c;
    y_reg <= y;
    port_d <= p;
    b_reg <= ba[7:4];
    acc <= ba[3:0];
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
  endtask

  // Timer load after a test: discarded when s is set
  task follow(input logic s);
    k = k + 8'h17;
    send(`STTL_OP_TIMER_LOAD, 4'h0, 1'b0, 4'h0, 6'h00, k);
    if (!s) exp_t = k;
    chk("skipped", skipped, s);
    chk("exec_en", exec_en, !s);
    chk("t1_load", t1_load, !s);
    chk("timer1_value", timer1_value, exp_t);
    chk("reload", timer1_reload_register, exp_t);
  endtask

  task timer_load_sc;
    send(`STTL_OP_TIMER_LOAD, 4'h0, 1'b0, 4'h0, 6'h00, 8'ha3);
    exp_t = 8'ha3;
    chk("exec_en", exec_en, 1'b1);
    chk("timer1_value", timer1_value, 8'ha3);
    chk("reload", timer1_reload_register, 8'ha3);
  endtask

  task mem_bit_sc;
    for (int j = 0; j < 4; j++) begin
      for (int v = 0; v < 2; v++) begin
        send(`STTL_OP_MEM_BIT | 10'(j), v ? 4'h1 << j : ~(4'h1 << j), 1'b0, 4'h0, 6'h00, 8'h00);
        chk("skip_set", skip_set, v == 0);
        follow(v == 0);
      end
    end
  endtask

  task carry_sc;
    for (int c = 0; c < 2; c++) begin
      send(`STTL_OP_CARRY_TEST, 4'h0, 1'(c), 4'h0, 6'h00, 8'h00);
      chk("skip_set", skip_set, c == 0);
      chk("exec_en", exec_en, 1'b1);
      follow(c == 0);
    end
  endtask

  task port_sc;
    for (int y = 0; y < 7; y++) begin
      for (int v = 0; v < 2; v++) begin
        send(`STTL_OP_PORT_WORD1, 4'h0, 1'b0, 4'h0, 6'h00, 8'h00);
        chk("skip_set", skip_set, 1'b0);
        send(`STTL_OP_PORT_WORD2, 4'h0, 1'b0, 4'(y), v ? 6'h3f : ~(6'h01 << y), 8'h00);
        chk("skip_set", skip_set, v == 0 && y < 6);
        chk("bad_sel", bad_sel, y > 5);
        follow(v == 0 && y < 6);
      end
    end
  endtask

  // Verdict and end of run
  task stop_test;
    $display("Mismatches %0d, checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Reset, then the scenarios
  initial begin
    repeat (4) @(posedge clk_sys);
    chk("exec_en", exec_en, 1'b0);
    rst <= 1'b0;
    timer_load_sc;
    mem_bit_sc;
    carry_sc;
    port_sc;
    stop_test;
  end
endmodule // skip_test_and_timer_load_ops_test
